// ### include/ufm_pkg.sv
// constants, field layouts and carrier types of the underfrequency monitor
// assumes: frequency inputs and rated frequency share one unit and scale
package ufm_pkg;

  // --------------------------------------------------------------------
  // timing
  // --------------------------------------------------------------------
  localparam int CLK_KHZ     = 250000;
  localparam int TICK_MS     = 10;
  localparam int TICK_CYC    = TICK_MS * CLK_KHZ;
  localparam int RST_DLY_MS  = 80;
  localparam int RST_TICKS   = RST_DLY_MS / TICK_MS;
  localparam int TICK_W      = 22;

  // --------------------------------------------------------------------
  // register offsets (byte addresses)
  // --------------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_LIM1  = 8'h04;
  localparam logic [7:0] OFS_LIM2  = 8'h08;
  localparam logic [7:0] OFS_DLY1  = 8'h0C;
  localparam logic [7:0] OFS_DLY2  = 8'h10;
  localparam logic [7:0] OFS_CLASS = 8'h14;
  localparam logic [7:0] OFS_ENSEL = 8'h18;
  localparam logic [7:0] OFS_HYST  = 8'h1C;
  localparam logic [7:0] OFS_STAT  = 8'h20;
  localparam logic [7:0] OFS_ISTAT = 8'h24;
  localparam logic [7:0] OFS_IMASK = 8'h28;
  localparam logic [7:0] OFS_ACK   = 8'h2C;

  // --------------------------------------------------------------------
  // field positions
  // --------------------------------------------------------------------
  localparam int CTRL_ON_POS   = 0;
  localparam int CTRL_SACK_POS = 2;
  localparam int CLASS_W       = 3;
  localparam int CLASS_L2_POS  = 4;
  localparam int ENSEL_W       = 6;
  localparam int ENSEL_L2_POS  = 8;
  localparam int ISTAT_CLR_POS = 2;

  // --------------------------------------------------------------------
  // ranges and reset values (limits in 0.1 %, delays in ticks)
  // --------------------------------------------------------------------
  localparam int LIM_W = 11;
  localparam int DLY_W = 14;
  localparam int HYS_W = 8;
  localparam int FRQ_W = 16;
  localparam int PRD_W = 27;
  localparam logic [LIM_W-1:0] LIM_MIN   = 11'h29B;
  localparam logic [LIM_W-1:0] LIM_MAX   = 11'h578;
  localparam logic [LIM_W-1:0] LIM_SCALE = 11'h3E8;
  localparam logic [LIM_W-1:0] LIM1_RST  = 11'h3E4;
  localparam logic [LIM_W-1:0] LIM2_RST  = 11'h3D4;
  localparam logic [DLY_W-1:0] DLY_MAX   = 14'h270F;
  localparam logic [DLY_W-1:0] DLY1_RST  = 14'h0096;
  localparam logic [DLY_W-1:0] DLY2_RST  = 14'h0006;
  localparam logic [HYS_W-1:0] HYS_RST   = 8'h05;
  localparam logic [3:0]       CTRL_RST  = 4'hF;

  // alarm classes A..F and control
  localparam logic [CLASS_W-1:0] CLS_A    = 3'h0;
  localparam logic [CLASS_W-1:0] CLS_B    = 3'h1;
  localparam logic [CLASS_W-1:0] CLS_CTRL = 3'h6;

  // enable selection codes; 32..63 pick logic_flag_n[code-32]
  localparam logic [ENSEL_W-1:0] EN_ALWAYS = 6'h00;
  localparam logic [ENSEL_W-1:0] EN_LOCK   = 6'h01;
  localparam logic [ENSEL_W-1:0] EN_FLAG0  = 6'h20;

  // --------------------------------------------------------------------
  // carrier types
  // --------------------------------------------------------------------
  typedef struct packed {
    logic               on;
    logic               self_ack;
    logic [LIM_W-1:0]   lim;
    logic [DLY_W-1:0]   dly;
    logic [CLASS_W-1:0] cls;
    logic [ENSEL_W-1:0] ensel;
  } ufm_cfg_t;

  typedef struct packed {
    logic               cmd;
    logic               msg;
    logic               start;
    logic [CLASS_W-1:0] cls;
  } ufm_alarm_t;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'h1,
    ST_TIMING  = 4'h2,
    ST_TRIPPED = 4'h4,
    ST_RELEASE = 4'h8
  } ufm_state_t;

endpackage

// ### src/ufm_monitor.sv
// two-level definite-time underfrequency monitor with register port
// assumes: one 250 MHz clock, synchronous inputs, rated frequency nonzero
//
// Contract
// R01: two independent levels, own config, own alarm; the code shares one hysteresis between both levels
// R02: level trip raises its command flag, message
// R03: fixed pickup time, independent of deviation
// R04: per-level on/off, default on, off never trips
// R05: software keeps level-1 limit above level-2
// R06: limits 66.7 to 140.0 percent, defaults set
// R07: limit equals rated frequency times percentage
// R08: trip after uninterrupted time at or below
// R09: release tripped state 80 ms after clearing
// R10: delay 0.00 to 99.99 s, defaults set
// R11: rise above limit plus hysteresis clears timer
// R12: per-level alarm class A..F or control
// R13: self-acknowledge clears alarm when fault gone
// R14: without self-acknowledge, alarm held until acknowledged
// R15: always enable evaluates continuously
// R16: lock enable suspends while lock input true
// R17: enable may follow any of 32 flags
// R18: delay counts 10 ms ticks, 14 bits
// R19: hysteresis margin is configurable
`timescale 1ns/10ps

module ufm_monitor #(
  parameter int TICK_CYC = ufm_pkg::TICK_CYC
) (
  input  wire logic                              core_clk,
  input  wire logic                              rst_n,
  input  wire logic [7:0]                        reg_addr,
  input  wire logic [31:0]                       reg_wdata,
  input  wire logic                              reg_wr,
  input  wire logic                              reg_rd,
  output      logic [31:0]                       reg_rdata,
  input  wire logic [ufm_pkg::FRQ_W-1:0]         freq_meas,
  input  wire logic [ufm_pkg::FRQ_W-1:0]         freq_rated,
  input  wire logic                              lock_mon,
  input  wire logic [31:0]                       logic_flag_n,
  input  wire logic                              ext_ack,
  output      ufm_pkg::ufm_alarm_t [1:0]         alarm,
  output      logic                              irq
);

  // --------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------
  function automatic logic [ufm_pkg::PRD_W-1:0] ufm_scale(
    input logic [ufm_pkg::FRQ_W-1:0] f,
    input logic [ufm_pkg::LIM_W-1:0] p
  );
    ufm_scale = ufm_pkg::PRD_W'(f) * ufm_pkg::PRD_W'(p);
  endfunction

  function automatic logic [ufm_pkg::LIM_W-1:0] ufm_clamp_lim(
    input logic [31:0] v
  );
    if (v < 32'(ufm_pkg::LIM_MIN)) begin
      ufm_clamp_lim = ufm_pkg::LIM_MIN;
    end else if (v > 32'(ufm_pkg::LIM_MAX)) begin
      ufm_clamp_lim = ufm_pkg::LIM_MAX;
    end else begin
      ufm_clamp_lim = v[ufm_pkg::LIM_W-1:0];
    end
  endfunction

  function automatic logic [ufm_pkg::DLY_W-1:0] ufm_clamp_dly(
    input logic [31:0] v
  );
    if (v > 32'(ufm_pkg::DLY_MAX)) begin
      ufm_clamp_dly = ufm_pkg::DLY_MAX;
    end else begin
      ufm_clamp_dly = v[ufm_pkg::DLY_W-1:0];
    end
  endfunction

  // --------------------------------------------------------------------
  // 10 ms tick from the core clock
  // --------------------------------------------------------------------
  logic [ufm_pkg::TICK_W-1:0] tick_cnt_r;
  logic                       tick;

  assign tick = (tick_cnt_r == ufm_pkg::TICK_W'(TICK_CYC - 1));

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_r <= '0;
    end else if (tick) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 1'b1; // R18
    end
  end

  // --------------------------------------------------------------------
  // configuration registers
  // --------------------------------------------------------------------
  ufm_pkg::ufm_cfg_t [1:0]      cfg_r;
  logic [ufm_pkg::HYS_W-1:0]    hyst_r;
  logic [3:0]                   imask_r;
  logic [3:0]                   istat_r;
  logic [3:0]                   istat_nxt;
  logic [31:0]                  rdata_r;
  logic [31:0]                  rdata_nxt;

  wire wr_ctrl  = reg_wr && (reg_addr == ufm_pkg::OFS_CTRL);
  wire wr_lim1  = reg_wr && (reg_addr == ufm_pkg::OFS_LIM1);
  wire wr_lim2  = reg_wr && (reg_addr == ufm_pkg::OFS_LIM2);
  wire wr_dly1  = reg_wr && (reg_addr == ufm_pkg::OFS_DLY1);
  wire wr_dly2  = reg_wr && (reg_addr == ufm_pkg::OFS_DLY2);
  wire wr_class = reg_wr && (reg_addr == ufm_pkg::OFS_CLASS);
  wire wr_ensel = reg_wr && (reg_addr == ufm_pkg::OFS_ENSEL);
  wire wr_hyst  = reg_wr && (reg_addr == ufm_pkg::OFS_HYST);
  wire wr_imask = reg_wr && (reg_addr == ufm_pkg::OFS_IMASK);
  wire wr_ack   = reg_wr && (reg_addr == ufm_pkg::OFS_ACK);
  wire rd_istat = reg_rd && (reg_addr == ufm_pkg::OFS_ISTAT);

  wire [1:0] wr_lim = {wr_lim2, wr_lim1};
  wire [1:0] wr_dly = {wr_dly2, wr_dly1};
  wire [ufm_pkg::LIM_W-1:0] lim_in = ufm_clamp_lim(reg_wdata); // R06
  wire [ufm_pkg::DLY_W-1:0] dly_in = ufm_clamp_dly(reg_wdata); // R10

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r[0] <= '{on: 1'b1, self_ack: 1'b1, lim: ufm_pkg::LIM1_RST,
                    dly: ufm_pkg::DLY1_RST, cls: ufm_pkg::CLS_A,
                    ensel: ufm_pkg::EN_ALWAYS};
      cfg_r[1] <= '{on: 1'b1, self_ack: 1'b1, lim: ufm_pkg::LIM2_RST,
                    dly: ufm_pkg::DLY2_RST, cls: ufm_pkg::CLS_B,
                    ensel: ufm_pkg::EN_ALWAYS};
      hyst_r   <= ufm_pkg::HYS_RST;
      imask_r  <= '0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (wr_ctrl) begin
          cfg_r[i].on       <= reg_wdata[ufm_pkg::CTRL_ON_POS + i];   // R04
          cfg_r[i].self_ack <= reg_wdata[ufm_pkg::CTRL_SACK_POS + i]; // R13
        end
        if (wr_lim[i]) begin
          cfg_r[i].lim <= lim_in;
        end
        if (wr_dly[i]) begin
          cfg_r[i].dly <= dly_in;
        end
        if (wr_class) begin
          cfg_r[i].cls <= reg_wdata[i*ufm_pkg::CLASS_L2_POS +:
                                    ufm_pkg::CLASS_W]; // R12
        end
        if (wr_ensel) begin
          cfg_r[i].ensel <= reg_wdata[i*ufm_pkg::ENSEL_L2_POS +:
                                      ufm_pkg::ENSEL_W];
        end
      end
      if (wr_hyst) begin
        hyst_r <= reg_wdata[ufm_pkg::HYS_W-1:0]; // R19
      end
      if (wr_imask) begin
        imask_r <= reg_wdata[3:0];
      end
    end
  end

  // --------------------------------------------------------------------
  // per-level comparison and enable gating
  // --------------------------------------------------------------------
  // cross-multiplied to avoid a divider: f*1000 against rated*percent
  wire [ufm_pkg::PRD_W-1:0] f_scaled = ufm_scale(freq_meas,
                                                 ufm_pkg::LIM_SCALE);
  logic [1:0] below;
  logic [1:0] above_h;
  logic [1:0] active;

  for (genvar g = 0; g < 2; g++) begin : g_cmp
    wire [ufm_pkg::LIM_W-1:0] lim_h =
      cfg_r[g].lim + ufm_pkg::LIM_W'(hyst_r);
    wire [ufm_pkg::ENSEL_W-1:0] sel = cfg_r[g].ensel;
    wire flag_on = logic_flag_n[sel[4:0]];
    wire gate = (sel == ufm_pkg::EN_LOCK) ? !lock_mon :         // R16
                sel[5] ? flag_on :                               // R17
                1'b1;                                            // R15
    assign below[g]   = f_scaled <= ufm_scale(freq_rated,
                                              cfg_r[g].lim);    // R07
    assign above_h[g] = f_scaled > ufm_scale(freq_rated, lim_h); // R11
    assign active[g]  = cfg_r[g].on && gate;                     // R04
  end

  // --------------------------------------------------------------------
  // per-level pickup, reset delay and alarm latch
  // --------------------------------------------------------------------
  ufm_pkg::ufm_state_t [1:0]        st_r;
  ufm_pkg::ufm_state_t [1:0]        st_nxt;
  logic [1:0][ufm_pkg::DLY_W-1:0]   tmr_r;
  logic [1:0][ufm_pkg::DLY_W-1:0]   tmr_nxt;
  logic [1:0][3:0]                  rcnt_r;
  logic [1:0][3:0]                  rcnt_nxt;
  logic [1:0]                       alarm_r;
  logic [1:0]                       alarm_nxt;
  logic [1:0]                       trip;
  logic [1:0]                       clr_ev;
  logic [1:0]                       start_r;

  wire [1:0] ack = ({2{ext_ack}} | ({2{wr_ack}} & reg_wdata[1:0]));

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      st_nxt[i]   = st_r[i];
      tmr_nxt[i]  = tmr_r[i];
      rcnt_nxt[i] = rcnt_r[i];
      trip[i]     = 1'b0;
      if (!active[i]) begin
        st_nxt[i]   = ufm_pkg::ST_IDLE;
        tmr_nxt[i]  = '0;
        rcnt_nxt[i] = '0;
      end else begin
        case (st_r[i])
          ufm_pkg::ST_IDLE: begin
            tmr_nxt[i] = '0;
            if (below[i]) begin
              st_nxt[i] = ufm_pkg::ST_TIMING;
            end
          end
          ufm_pkg::ST_TIMING: begin
            if (above_h[i]) begin
              st_nxt[i]  = ufm_pkg::ST_IDLE; // R11
              tmr_nxt[i] = '0;
            end else if (below[i] && (tmr_r[i] >= cfg_r[i].dly)) begin
              st_nxt[i] = ufm_pkg::ST_TRIPPED; // R03 R08
              trip[i]   = 1'b1;
            end else if (below[i] && tick) begin
              tmr_nxt[i] = tmr_r[i] + 1'b1; // R18
            end
          end
          ufm_pkg::ST_TRIPPED: begin
            rcnt_nxt[i] = '0;
            if (!below[i]) begin
              st_nxt[i] = ufm_pkg::ST_RELEASE;
            end
          end
          ufm_pkg::ST_RELEASE: begin
            if (below[i]) begin
              st_nxt[i] = ufm_pkg::ST_TRIPPED;
            end else if (tick) begin
              if (rcnt_r[i] == 4'(ufm_pkg::RST_TICKS - 1)) begin
                st_nxt[i]  = ufm_pkg::ST_IDLE; // R09
                tmr_nxt[i] = '0;
              end else begin
                rcnt_nxt[i] = rcnt_r[i] + 1'b1;
              end
            end
          end
          default: begin
            st_nxt[i] = ufm_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  // fault is held while tripped or counting down the reset delay
  wire [1:0] fault = {st_r[1] == ufm_pkg::ST_TRIPPED ||
                      st_r[1] == ufm_pkg::ST_RELEASE,
                      st_r[0] == ufm_pkg::ST_TRIPPED ||
                      st_r[0] == ufm_pkg::ST_RELEASE};

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      alarm_nxt[i] = alarm_r[i];
      if (!cfg_r[i].on) begin
        alarm_nxt[i] = 1'b0; // R04
      end else if (trip[i]) begin
        alarm_nxt[i] = 1'b1; // R02
      end else if (!fault[i] && cfg_r[i].self_ack) begin
        alarm_nxt[i] = 1'b0; // R13
      end else if (!fault[i] && ack[i]) begin
        alarm_nxt[i] = 1'b0; // R14
      end
      clr_ev[i] = alarm_r[i] && !alarm_nxt[i];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r    <= '{ufm_pkg::ST_IDLE, ufm_pkg::ST_IDLE};
      tmr_r   <= '0;
      rcnt_r  <= '0;
      alarm_r <= '0;
      start_r <= '0;
    end else begin
      st_r    <= st_nxt;
      tmr_r   <= tmr_nxt;
      rcnt_r  <= rcnt_nxt;
      alarm_r <= alarm_nxt;
      start_r <= trip; // R08
    end
  end

  // levels have separate limits, delays and alarms but share one hysteresis; software keeps limit 1 above limit 2
  for (genvar g = 0; g < 2; g++) begin : g_out
    assign alarm[g].cmd   = alarm_r[g]; // R01 R02
    assign alarm[g].msg   = alarm_r[g]; // R02
    assign alarm[g].start = start_r[g];
    assign alarm[g].cls   = cfg_r[g].cls; // R12
  end

  // --------------------------------------------------------------------
  // interrupt status: set wins over the clearing read
  // --------------------------------------------------------------------
  wire [3:0] ev = {clr_ev, trip};

  assign istat_nxt = (rd_istat ? 4'h0 : istat_r) | ev;
  assign irq = |(istat_r & imask_r);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      istat_r <= '0;
    end else begin
      istat_r <= istat_nxt;
    end
  end

  // --------------------------------------------------------------------
  // read port, data one cycle after the strobe
  // --------------------------------------------------------------------
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    case (reg_addr)
      ufm_pkg::OFS_CTRL:  rdata_nxt = {28'h0, cfg_r[1].self_ack,
                                       cfg_r[0].self_ack,
                                       cfg_r[1].on, cfg_r[0].on};
      ufm_pkg::OFS_LIM1:  rdata_nxt = 32'(cfg_r[0].lim);
      ufm_pkg::OFS_LIM2:  rdata_nxt = 32'(cfg_r[1].lim);
      ufm_pkg::OFS_DLY1:  rdata_nxt = 32'(cfg_r[0].dly);
      ufm_pkg::OFS_DLY2:  rdata_nxt = 32'(cfg_r[1].dly);
      ufm_pkg::OFS_CLASS: rdata_nxt = {25'h0, cfg_r[1].cls, 1'b0,
                                       cfg_r[0].cls};
      ufm_pkg::OFS_ENSEL: rdata_nxt = {18'h0, cfg_r[1].ensel, 2'h0,
                                       cfg_r[0].ensel};
      ufm_pkg::OFS_HYST:  rdata_nxt = 32'(hyst_r);
      ufm_pkg::OFS_STAT:  rdata_nxt = {24'h0, st_r[1], st_r[0]} |
                                      {20'h0, fault, alarm_r, 8'h00};
      ufm_pkg::OFS_ISTAT: rdata_nxt = 32'(istat_r);
      ufm_pkg::OFS_IMASK: rdata_nxt = 32'(imask_r);
      default:            rdata_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= '0;
    end else if (reg_rd) begin
      rdata_r <= rdata_nxt;
    end else begin
      rdata_r <= '0;
    end
  end

  assign reg_rdata = rdata_r;

endmodule

// ### test/ufm_monitor_props.sv
// checker of the underfrequency monitor, seen from its ports only
// assumes: bound into ufm_monitor, one clock, rst_n async active low
`timescale 1ns/10ps

module ufm_monitor_props #(
  parameter int TICK_CYC = 4
) (
  input wire logic                      core_clk,
  input wire logic                      rst_n,
  input wire logic [7:0]                reg_addr,
  input wire logic [31:0]               reg_wdata,
  input wire logic                      reg_wr,
  input wire logic                      reg_rd,
  input wire logic [31:0]               reg_rdata,
  input wire logic [15:0]               freq_meas,
  input wire logic [15:0]               freq_rated,
  input wire logic                      lock_mon,
  input wire logic [31:0]               logic_flag_n,
  input wire logic                      ext_ack,
  input wire ufm_pkg::ufm_alarm_t [1:0] alarm,
  input wire logic                      irq
);
  // ------
  // helpers
  // ------
  // above the highest legal limit: no level can see a dip
  wire logic high_w;
  assign high_w = (32'(freq_meas) * 32'h3E8) >
                  (32'(freq_rated) * 32'(ufm_pkg::LIM_MAX));

  default clocking cb_main @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_class_wr;
    reg_wr && reg_addr == ufm_pkg::OFS_CLASS ##1 !reg_wr;
  endsequence
  sequence s_high3;
    high_w [*3];
  endsequence
  sequence s_off2;
    reg_wr && reg_addr == ufm_pkg::OFS_CTRL && !reg_wdata[1];
  endsequence

  // ------
  // properties
  // ------
  property p_rd_idle;
    !$past(reg_rd) |-> reg_rdata == 32'h0;
  endproperty
  property p_msg_cmd;
    alarm[0].msg == alarm[0].cmd && alarm[1].msg == alarm[1].cmd;
  endproperty
  property p_start_rise;
    $rose(alarm[0].cmd) |-> alarm[0].start;
  endproperty
  property p_start_once;
    alarm[1].start |-> alarm[1].cmd ##1 !alarm[1].start;
  endproperty
  property p_cls_wr;
    s_class_wr |=> alarm[0].cls == 3'($past(reg_wdata, 2)) &&
                   alarm[1].cls == 3'($past(reg_wdata, 2) >> 4);
  endproperty
  property p_off_clr;
    s_off2 |-> ##2 (!alarm[1].cmd) [*4];
  endproperty
  property p_trip_below;
    $rose(alarm[0].cmd) |-> !$past(high_w, 3);
  endproperty
  property p_no_trip_hi;
    s_high3 |=> !$rose(alarm[1].cmd);
  endproperty

  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside its slot");
  a_msg_cmd: assert property (p_msg_cmd)
    else $error("message differs from command flag");
  a_start_rise: assert property (p_start_rise)
    else $error("trip without class action start");
  a_start_once: assert property (p_start_once)
    else $error("start pulse wrong");
  a_cls_wr: assert property (p_cls_wr)
    else $error("alarm class not as written");
  a_off_clr: assert property (p_off_clr)
    else $error("level off but alarm set");
  a_trip_below: assert property (p_trip_below)
    else $error("trip without dip");
  a_no_trip_hi: assert property (p_no_trip_hi)
    else $error("trip while frequency high");
endmodule

bind ufm_monitor ufm_monitor_props #(.TICK_CYC(TICK_CYC)) i_props (
  .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .freq_meas(freq_meas),
  .freq_rated(freq_rated), .lock_mon(lock_mon),
  .logic_flag_n(logic_flag_n), .ext_ack(ext_ack),
  .alarm(alarm), .irq(irq)
);

// ### test/ufm_grid_model.sv
// far-side model: frequency source and alarm handling
// assumes: shares the monitor clock, needs no reset
`timescale 1ns/10ps

module ufm_grid_model (
  input  wire logic                      core_clk,
  input  wire logic [10:0]               pct_set,
  input  wire logic [15:0]               rated_set,
  input  wire logic                      ack_req,
  input  wire ufm_pkg::ufm_alarm_t [1:0] alarm,
  output      logic [15:0]               freq_meas,
  output      logic [15:0]               freq_rated,
  output      logic                      ext_ack,
  output      logic [15:0]               starts
);
  initial begin
    ext_ack = 1'b0;
    starts = 16'h0000;
  end

  // truncating division keeps a commanded dip a real dip
  always @(posedge core_clk) begin
    freq_rated <= rated_set;
    freq_meas <= 16'((32'(rated_set) * 32'(pct_set)) / 32'h3E8);
    ext_ack <= ack_req;
    if (alarm[0].start) starts[7:0] <= starts[7:0] + 8'h01;
    if (alarm[1].start) starts[15:8] <= starts[15:8] + 8'h01;
  end
endmodule

// ### test/ufm_monitor_test.sv
// self-checking bench of the underfrequency monitor
// assumes: ufm_grid_model on the far side, checker bound into the design
`timescale 1ns/10ps
`define CHK(nm, e, a) begin \
  checked++; \
  if ((a) !== (e)) begin \
    failures++; \
    $display("Error %s expected %0h seen %0h", nm, (e), (a)); \
  end \
end

module ufm_monitor_test;
  localparam int TK = 4;
  logic        core_clk     = 1'b0;
  logic        rst_n        = 1'b0;
  logic [7:0]  reg_addr     = 8'h00;
  logic [31:0] reg_wdata    = 32'h0;
  logic        reg_wr       = 1'b0;
  logic        reg_rd       = 1'b0;
  logic [10:0] pct          = 11'h3ED;
  logic [15:0] rated        = 16'h1388;
  logic        ack_req      = 1'b0;
  logic        lock_mon     = 1'b0;
  logic [31:0] logic_flag_n = 32'h0;
  logic [31:0] reg_rdata;
  logic [15:0] freq_meas;
  logic [15:0] freq_rated;
  logic        ext_ack;
  logic        irq;
  logic [15:0] starts;
  ufm_pkg::ufm_alarm_t [1:0] alarm;
  int          failures = 0;
  int          checked  = 0;
  int          cyc      = 0;
  int          k;
  logic [31:0] v;

  always #2 core_clk = ~core_clk;

  ufm_monitor #(.TICK_CYC(TK)) i_dut (
    .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .freq_meas(freq_meas),
    .freq_rated(freq_rated), .lock_mon(lock_mon),
    .logic_flag_n(logic_flag_n), .ext_ack(ext_ack),
    .alarm(alarm), .irq(irq));
  ufm_grid_model i_grid (
    .core_clk(core_clk), .pct_set(pct), .rated_set(rated),
    .ack_req(ack_req), .alarm(alarm), .freq_meas(freq_meas),
    .freq_rated(freq_rated), .ext_ack(ext_ack), .starts(starts));

  // ------
  // expectations and bus cycles
  // ------
  function automatic logic [31:0] exp_lim(input logic [31:0] w);
    if (w < 32'(ufm_pkg::LIM_MIN)) return 32'(ufm_pkg::LIM_MIN);
    if (w > 32'(ufm_pkg::LIM_MAX)) return 32'(ufm_pkg::LIM_MAX);
    return w;
  endfunction
  function automatic logic [31:0] exp_dly(input logic [31:0] w);
    return (w > 32'(ufm_pkg::DLY_MAX)) ? 32'(ufm_pkg::DLY_MAX) : w;
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK("rdata", e, reg_rdata)
  endtask
  task automatic hold(input logic [10:0] p, input int n);
    @(posedge core_clk);
    pct <= p;
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic give_verdict();
    $display("failures %0d checked %0d", failures, checked);
    if (failures == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // run is near 1000 cycles; far above it is a hang
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      give_verdict();
    end
  end

  // ------
  // scenarios
  // ------
  initial begin
    v = $urandom(32'h910C);
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(ufm_pkg::OFS_CTRL, 32'(ufm_pkg::CTRL_RST));
    rd(ufm_pkg::OFS_LIM1, 32'(ufm_pkg::LIM1_RST));
    rd(ufm_pkg::OFS_LIM2, 32'(ufm_pkg::LIM2_RST));
    rd(ufm_pkg::OFS_DLY1, 32'(ufm_pkg::DLY1_RST));
    rd(ufm_pkg::OFS_DLY2, 32'(ufm_pkg::DLY2_RST));
    rd(ufm_pkg::OFS_CLASS, 32'h10);
    rd(ufm_pkg::OFS_ENSEL, 32'h0);
    rd(ufm_pkg::OFS_HYST, 32'(ufm_pkg::HYS_RST));
    rd(ufm_pkg::OFS_IMASK, 32'h0);
    rd(8'h30, 32'h0);
    `CHK("cls2", ufm_pkg::CLS_B, alarm[1].cls)
    wr(ufm_pkg::OFS_LIM2, 32'h64);
    rd(ufm_pkg::OFS_LIM2, exp_lim(32'h64));
    wr(ufm_pkg::OFS_LIM1, 32'h7FF);
    rd(ufm_pkg::OFS_LIM1, exp_lim(32'h7FF));
    wr(ufm_pkg::OFS_DLY1, 32'h3FFF);
    rd(ufm_pkg::OFS_DLY1, exp_dly(32'h3FFF));
    wr(ufm_pkg::OFS_LIM1, 32'(ufm_pkg::LIM1_RST));
    wr(ufm_pkg::OFS_LIM2, 32'(ufm_pkg::LIM2_RST));
    for (k = 0; k < 7; k++) begin
      v = 32'(k) | (32'(6 - k) << 4);
      wr(ufm_pkg::OFS_CLASS, v);
      rd(ufm_pkg::OFS_CLASS, v);
      `CHK("cls1", 3'(k), alarm[0].cls)
    end
    // level 2 alone until CTRL is written with 0xB for the level-1 check, its trip unmasked
    wr(ufm_pkg::OFS_CTRL, 32'hE);
    wr(ufm_pkg::OFS_IMASK, 32'h2);
    rated <= 16'h0800 + 16'($urandom % 32'h7000);
    for (k = 0; k < 2; k++) begin
      hold((k == 0) ? 11'h3CA : 11'h2BC + 11'($urandom % 32'hFA), 18);
      `CHK("cmd2 early", 1'b0, alarm[1].cmd)
      hold(pct, 18);
      `CHK("cmd2", 1'b1, alarm[1].cmd)
      `CHK("msg2", 1'b1, alarm[1].msg)
      `CHK("irq", 1'b1, irq)
      rd(ufm_pkg::OFS_ISTAT, 32'h2);
      `CHK("irq clr", 1'b0, irq)
      hold(11'h3ED, 26);
      `CHK("cmd2 held", 1'b1, alarm[1].cmd)
      hold(11'h3ED, 20);
      `CHK("cmd2 rel", 1'b0, alarm[1].cmd)
      rd(ufm_pkg::OFS_ISTAT, 32'h8);
    end
    `CHK("starts2", 8'h02, starts[15:8])
    hold(11'h3C5, 14);
    hold(11'h5DC, 8);
    hold(11'h3C5, 14);
    `CHK("cmd2 restart", 1'b0, alarm[1].cmd)
    hold(11'h5DC, 8);
    wr(ufm_pkg::OFS_HYST, 32'h32);
    hold(11'h3C5, 14);
    hold(11'h3F2, 8);
    hold(11'h3C5, 20);
    `CHK("cmd2 band", 1'b1, alarm[1].cmd)
    wr(ufm_pkg::OFS_HYST, 32'(ufm_pkg::HYS_RST));
    hold(11'h3ED, 46);
    wr(ufm_pkg::OFS_CTRL, 32'h6);
    hold(11'h3CA, 36);
    hold(11'h3ED, 60);
    `CHK("cmd2 latched", 1'b1, alarm[1].cmd)
    @(posedge core_clk);
    ack_req <= 1'b1;
    hold(11'h3ED, 1);
    ack_req <= 1'b0;
    hold(11'h3ED, 3);
    `CHK("cmd2 acked", 1'b0, alarm[1].cmd)
    wr(ufm_pkg::OFS_CTRL, 32'hE);
    hold(11'h2BC, 36);
    wr(ufm_pkg::OFS_CTRL, 32'hC);
    hold(11'h2BC, 60);
    `CHK("cmd2 off", 1'b0, alarm[1].cmd)
    hold(11'h3ED, 4);
    wr(ufm_pkg::OFS_CTRL, 32'hE);
    wr(ufm_pkg::OFS_ENSEL, 32'h100);
    lock_mon <= 1'b1;
    hold(11'h2BC, 40);
    `CHK("cmd2 locked", 1'b0, alarm[1].cmd)
    @(posedge core_clk);
    lock_mon <= 1'b0;
    hold(11'h2BC, 36);
    `CHK("cmd2 unlocked", 1'b1, alarm[1].cmd)
    hold(11'h3ED, 46);
    k = int'($urandom % 32);
    wr(ufm_pkg::OFS_ENSEL, 32'(ufm_pkg::EN_FLAG0 + 6'(k)) << 8);
    logic_flag_n <= ~(32'h1 << k);
    hold(11'h2BC, 40);
    `CHK("cmd2 flag low", 1'b0, alarm[1].cmd)
    @(posedge core_clk);
    logic_flag_n <= 32'h1 << k;
    hold(11'h2BC, 36);
    `CHK("cmd2 flag high", 1'b1, alarm[1].cmd)
    hold(11'h3ED, 46);
    wr(ufm_pkg::OFS_ENSEL, 32'h0);
    wr(ufm_pkg::OFS_CTRL, 32'hB);
    wr(ufm_pkg::OFS_DLY1, 32'h2);
    hold(11'h3D9, 30);
    `CHK("cmd1", 1'b1, alarm[0].cmd)
    `CHK("cmd2 quiet", 1'b0, alarm[1].cmd)
    `CHK("starts1", 8'h01, starts[7:0])
    hold(11'h3ED, 46);
    rd(ufm_pkg::OFS_STAT, 32'h111);
    wr(ufm_pkg::OFS_ACK, 32'h1);
    rd(ufm_pkg::OFS_STAT, 32'h11);
    give_verdict();
  end
endmodule
